/* File: src/cbu_consts.vh */
/*
 Constants of the compare and branch unit: register offsets, instruction
 field positions, operation and indicator codes, status bit positions,
 reset values and cycle counts.
 Assumes it is included by bare name from the unit's single design file.
*/
`ifndef CBU_CONSTS_VH
`define CBU_CONSTS_VH

// ==========================================================
// register byte offsets
`define CBU_OFF_CTRL     12'h000
`define CBU_OFF_INSTR    12'h004
`define CBU_OFF_REG_LO   12'h008
`define CBU_OFF_REG_HI   12'h00C
`define CBU_OFF_MEM_LO   12'h010
`define CBU_OFF_MEM_HI   12'h014
`define CBU_OFF_FIELD    12'h018
`define CBU_OFF_CC       12'h01C
`define CBU_OFF_STATUS   12'h020
`define CBU_OFF_ARSIGN   12'h024
`define CBU_OFF_ARITH    12'h028
`define CBU_OFF_INDIR    12'h02C
`define CBU_OFF_INDEX    12'h040
`define CBU_INDEX_MASK   12'hFC0

// ==========================================================
// control bits
`define CBU_CTRL_GO      0
`define CBU_CTRL_MW      1

// ==========================================================
// instruction fields (bit n of the word is instr[n-1])
`define CBU_IW_FLAG      24
`define CBU_IW_X_HI      23
`define CBU_IW_X_LO      20
`define CBU_IW_OP_HI     19
`define CBU_IW_OP_LO     14
`define CBU_IW_IND_HI    13
`define CBU_IW_IND_LO    10
`define CBU_IW_ADR_HI    9
`define CBU_IW_ADR_LO    0
`define CBU_IW_W         25

// ==========================================================
// operation codes (octal 54, 56, 57, 60, 06)
`define CBU_OP_CMP_ALG   6'h2C
`define CBU_OP_CMP_ZERO  6'h2E
`define CBU_OP_CMP_ONES  6'h2F
`define CBU_OP_BRANCH    6'h30
`define CBU_OP_JUMP      6'h06

// ==========================================================
// indicator field codes
`define CBU_IND_EQUAL    4'h6
`define CBU_IND_GREATER  4'h7
`define CBU_IND_LESS     4'h5
`define CBU_IND_AR8      4'h1
`define CBU_IND_AR4      4'h2
`define CBU_IND_AR2      4'h3
`define CBU_IND_AR1      4'h4

// ==========================================================
// status bits
`define CBU_ST_EQUAL     0
`define CBU_ST_GREATER   1
`define CBU_ST_LESS      2
`define CBU_ST_BUSY      3
`define CBU_ST_TAKEN     4
`define CBU_ST_BADOP     5
`define CBU_ST_POS_LO    8

// ==========================================================
// cycle counts and reset values
`define CBU_CYC_CMP      2'h2
`define CBU_CYC_TAKEN    2'h1
`define CBU_CYC_NOTTAKEN 2'h2
`define CBU_CYC_JUMP     2'h1
`define CBU_CYC_BAD      2'h1
`define CBU_RST_WORD     25'h0000000

`endif

/* File: src/cbu_top.v */
/*
 Compare and branch unit: executes the algebraic and bit pattern compares,
 the indicator branches and the unconditional jump, with its register file
 on an APB slave.
 Assumes an APB3 master on pclk; the sequencer loads instruction, operands
 and index registers over the bus and reads back the control counter.
*/
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cbu_consts.vh"

module cbu_top #(
	parameter WORD_W = 25,
	parameter ADDR_W = 15
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        ce,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         instr_done
);

	localparam S_IDLE = 1'b0;
	localparam S_RUN  = 1'b1;
	localparam MAG_W  = 2 * (WORD_W - 1);

	// ==========================================================
	// decoding helpers

	// true for every offset that the slave answers
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a[11:6] == 6'h00 && a[5:0] <= `CBU_OFF_INDIR) ||
				((a & `CBU_INDEX_MASK) == `CBU_OFF_INDEX);
			if (a[1:0] != 2'h0) begin
				is_mapped = 1'b0;
			end
		end
	endfunction

	// indicator field to {known code, tested bit}; read only, never written
	function [1:0] branch_test;
		input [3:0] code;
		input [2:0] ind;
		input [3:0] pos;
		begin
			case (code)
				`CBU_IND_EQUAL:   branch_test = {1'b1, ind[0]};
				`CBU_IND_GREATER: branch_test = {1'b1, ind[1]};
				`CBU_IND_LESS:    branch_test = {1'b1, ind[2]};
				`CBU_IND_AR8:     branch_test = {1'b1, pos[3]};
				`CBU_IND_AR4:     branch_test = {1'b1, pos[2]};
				`CBU_IND_AR2:     branch_test = {1'b1, pos[1]};
				`CBU_IND_AR1:     branch_test = {1'b1, pos[0]};
				default:          branch_test = 2'b00;
			endcase
		end
	endfunction

	// ==========================================================
	// registers

	reg                 ctrl_mw_reg;
	reg [`CBU_IW_W-1:0] instr_reg;
	reg [WORD_W-1:0]    reg_lo_reg;
	reg [WORD_W-1:0]    reg_hi_reg;
	reg [WORD_W-1:0]    mem_lo_reg;
	reg [WORD_W-1:0]    mem_hi_reg;
	reg [WORD_W-1:0]    field_reg;
	reg [ADDR_W-1:0]    cc_reg;
	reg [2:0]           ind_reg;
	reg [3:0]           ar_sign_reg;
	reg [ADDR_W-1:0]    indir_reg;
	reg [ADDR_W-1:0]    index_mem [0:15];
	reg                 taken_reg;
	reg                 badop_reg;
	reg                 state_reg;
	reg [1:0]           cnt_reg;
	reg [2:0]           res_ind_reg;
	reg                 res_upd_reg;
	reg [ADDR_W-1:0]    res_cc_reg;
	reg                 res_taken_reg;
	reg                 res_bad_reg;

	// ==========================================================
	// bus strobes

	// a transfer completes on the edge where pready is already high
	wire        xfer  = psel & penable & pready;
	wire        wr    = xfer & pwrite;
	wire [11:0] woff  = paddr;
	wire        go    = wr && woff == `CBU_OFF_CTRL && pwdata[`CBU_CTRL_GO];
	wire        start = go && state_reg == S_IDLE;

	// ==========================================================
	// instruction fields

	wire                flag_bit = instr_reg[`CBU_IW_FLAG];
	wire [3:0]          xsel     = instr_reg[`CBU_IW_X_HI:`CBU_IW_X_LO];
	wire [5:0]          opcode   = instr_reg[`CBU_IW_OP_HI:`CBU_IW_OP_LO];
	wire [3:0]          ind_code = instr_reg[`CBU_IW_IND_HI:`CBU_IW_IND_LO];
	wire [9:0]          addr_fld = instr_reg[`CBU_IW_ADR_HI:`CBU_IW_ADR_LO];

	// sign indicators: one per arithmetic register, set while positive
	wire [3:0] pos_ind;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pos
			assign pos_ind[gi] = ~ar_sign_reg[gi];
		end
	endgenerate

	// ==========================================================
	// effective address

	// index register 0 always reads zero, so selector 0 adds nothing
	wire [ADDR_W-1:0] idx_val = (xsel == 4'h0) ? {ADDR_W{1'b0}} : index_mem[xsel];
	// the flag is indirection for transfers; the sequencer supplies the word
	wire [ADDR_W-1:0] base_adr = flag_bit ? indir_reg :
		{{(ADDR_W-10){1'b0}}, addr_fld};
	wire [ADDR_W-1:0] eff_adr  = base_adr + idx_val;
	wire [ADDR_W-1:0] cc_inc   = cc_reg + {{(ADDR_W-1){1'b0}}, 1'b1};

	// ==========================================================
	// compare datapath: reads operand registers only, never writes them

	// for compares the flag means field select: only masked bits take part
	wire [WORD_W-1:0] fmask = flag_bit ? field_reg : {WORD_W{1'b1}};
	// the go write may carry a new multiword bit; decode must see it now
	wire              mw_now = go ? pwdata[`CBU_CTRL_MW] : ctrl_mw_reg;
	wire [WORD_W-1:0] r_lo  = reg_lo_reg & fmask;
	wire [WORD_W-1:0] m_lo  = mem_lo_reg & fmask;
	wire [WORD_W-1:0] r_hi  = mw_now ? (reg_hi_reg & fmask) : {WORD_W{1'b0}};
	wire [WORD_W-1:0] m_hi  = mw_now ? (mem_hi_reg & fmask) : {WORD_W{1'b0}};

	// sign from the low word only; high word signs are dropped
	wire             r_neg = r_lo[WORD_W-1];
	wire             m_neg = m_lo[WORD_W-1];
	wire [MAG_W-1:0] r_mag = {r_hi[WORD_W-2:0], r_lo[WORD_W-2:0]};
	wire [MAG_W-1:0] m_mag = {m_hi[WORD_W-2:0], m_lo[WORD_W-2:0]};

	// signed relation as {less, greater, equal}, sign-magnitude words
	reg [2:0] alg_rel;
	always @* begin
		alg_rel = 3'b001;
		if (r_neg != m_neg) begin
			// differing signs decide alone, so +0 beats -0
			alg_rel = r_neg ? 3'b100 : 3'b010;
		end else if (r_mag == m_mag) begin
			alg_rel = 3'b001;
		end else if (r_mag > m_mag) begin
			alg_rel = r_neg ? 3'b100 : 3'b010;
		end else begin
			alg_rel = r_neg ? 3'b010 : 3'b100;
		end
	end

	// bit pattern tests run over whole words, sign bits included
	wire ones_ok  = ((r_lo & ~m_lo) == {WORD_W{1'b0}}) &&
		((r_hi & ~m_hi) == {WORD_W{1'b0}});
	wire zeros_ok = ((r_lo & m_lo) == {WORD_W{1'b0}}) &&
		((r_hi & m_hi) == {WORD_W{1'b0}});

	// ==========================================================
	// instruction decode: result, new counter and length

	wire [1:0] bt = branch_test(ind_code, ind_reg, pos_ind);

	reg [2:0]        dec_ind;
	reg              dec_upd;
	reg [ADDR_W-1:0] dec_cc;
	reg              dec_taken;
	reg              dec_bad;
	reg [1:0]        dec_cyc;
	always @* begin
		dec_ind   = 3'b000;
		dec_upd   = 1'b0;
		dec_cc    = cc_inc;
		dec_taken = 1'b0;
		dec_bad   = 1'b0;
		dec_cyc   = `CBU_CYC_BAD;
		case (opcode)
			`CBU_OP_CMP_ALG: begin
				dec_ind = alg_rel;
				dec_upd = 1'b1;
				dec_cyc = `CBU_CYC_CMP;
			end
			`CBU_OP_CMP_ONES: begin
				dec_ind = ones_ok ? 3'b001 : 3'b010;
				dec_upd = 1'b1;
				dec_cyc = `CBU_CYC_CMP;
			end
			`CBU_OP_CMP_ZERO: begin
				dec_ind = zeros_ok ? 3'b001 : 3'b010;
				dec_upd = 1'b1;
				dec_cyc = `CBU_CYC_CMP;
			end
			`CBU_OP_BRANCH: begin
				dec_bad = ~bt[1];
				if (bt[0]) begin
					dec_cc    = eff_adr;
					dec_taken = 1'b1;
					dec_cyc   = `CBU_CYC_TAKEN;
				end else begin
					dec_cc  = cc_inc;
					dec_cyc = `CBU_CYC_NOTTAKEN;
				end
			end
			`CBU_OP_JUMP: begin
				// field select has no meaning here; the flag is indirection
				dec_cc    = eff_adr;
				dec_taken = 1'b1;
				dec_cyc   = `CBU_CYC_JUMP;
			end
			default: begin
				dec_bad = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// execution sequencer

	// results are latched at start, so bus writes during a run do not leak in
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= S_IDLE;
			cnt_reg       <= 2'h0;
			res_ind_reg   <= 3'b000;
			res_upd_reg   <= 1'b0;
			res_cc_reg    <= {ADDR_W{1'b0}};
			res_taken_reg <= 1'b0;
			res_bad_reg   <= 1'b0;
			instr_done    <= 1'b0;
		end else if (ce) begin
			instr_done <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						state_reg     <= S_RUN;
						cnt_reg       <= dec_cyc - 2'h1;
						res_ind_reg   <= dec_ind;
						res_upd_reg   <= dec_upd;
						res_cc_reg    <= dec_cc;
						res_taken_reg <= dec_taken;
						res_bad_reg   <= dec_bad;
					end
				end
				S_RUN: begin
					if (cnt_reg == 2'h0) begin
						state_reg  <= S_IDLE;
						instr_done <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg - 2'h1;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	wire finish = state_reg == S_RUN && cnt_reg == 2'h0;

	// ==========================================================
	// indicators, counter and status flags

	// a compare finishing beats a same-cycle arithmetic result write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_reg   <= 3'b000;
			cc_reg    <= {ADDR_W{1'b0}};
			taken_reg <= 1'b0;
			badop_reg <= 1'b0;
		end else if (ce) begin
			if (finish && res_upd_reg) begin
				// one-hot load clears the other two in the same step
				ind_reg <= res_ind_reg;
			end else if (wr && woff == `CBU_OFF_ARITH) begin
				ind_reg[0] <= (pwdata[WORD_W-1:0] == {WORD_W{1'b0}});
			end
			if (finish) begin
				cc_reg    <= res_cc_reg;
				taken_reg <= res_taken_reg;
				badop_reg <= res_bad_reg;
			end else if (wr && woff == `CBU_OFF_CC) begin
				cc_reg <= pwdata[ADDR_W-1:0];
			end
		end
	end

	// ==========================================================
	// software writable registers

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_mw_reg <= 1'b0;
			instr_reg   <= `CBU_RST_WORD;
			reg_lo_reg  <= `CBU_RST_WORD;
			reg_hi_reg  <= `CBU_RST_WORD;
			mem_lo_reg  <= `CBU_RST_WORD;
			mem_hi_reg  <= `CBU_RST_WORD;
			field_reg   <= `CBU_RST_WORD;
			ar_sign_reg <= 4'h0;
			indir_reg   <= {ADDR_W{1'b0}};
		end else if (ce && wr) begin
			case (woff)
				`CBU_OFF_CTRL:   ctrl_mw_reg <= pwdata[`CBU_CTRL_MW];
				`CBU_OFF_INSTR:  instr_reg   <= pwdata[`CBU_IW_W-1:0];
				`CBU_OFF_REG_LO: reg_lo_reg  <= pwdata[WORD_W-1:0];
				`CBU_OFF_REG_HI: reg_hi_reg  <= pwdata[WORD_W-1:0];
				`CBU_OFF_MEM_LO: mem_lo_reg  <= pwdata[WORD_W-1:0];
				`CBU_OFF_MEM_HI: mem_hi_reg  <= pwdata[WORD_W-1:0];
				`CBU_OFF_FIELD:  field_reg   <= pwdata[WORD_W-1:0];
				`CBU_OFF_ARSIGN: ar_sign_reg <= pwdata[3:0];
				`CBU_OFF_INDIR:  indir_reg   <= pwdata[ADDR_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// index file; entry 0 is never written and reads as zero
	integer k;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (k = 0; k < 16; k = k + 1) begin
				index_mem[k] <= {ADDR_W{1'b0}};
			end
		end else if (ce && wr && (woff & `CBU_INDEX_MASK) == `CBU_OFF_INDEX &&
				woff[5:2] != 4'h0) begin
			index_mem[woff[5:2]] <= pwdata[ADDR_W-1:0];
		end
	end

	// ==========================================================
	// read mux

	reg [31:0] rd_word;
	always @* begin
		rd_word = 32'h00000000;
		case (woff)
			`CBU_OFF_CTRL:   rd_word[`CBU_CTRL_MW] = ctrl_mw_reg;
			`CBU_OFF_INSTR:  rd_word[`CBU_IW_W-1:0] = instr_reg;
			`CBU_OFF_REG_LO: rd_word[WORD_W-1:0] = reg_lo_reg;
			`CBU_OFF_REG_HI: rd_word[WORD_W-1:0] = reg_hi_reg;
			`CBU_OFF_MEM_LO: rd_word[WORD_W-1:0] = mem_lo_reg;
			`CBU_OFF_MEM_HI: rd_word[WORD_W-1:0] = mem_hi_reg;
			`CBU_OFF_FIELD:  rd_word[WORD_W-1:0] = field_reg;
			`CBU_OFF_CC:     rd_word[ADDR_W-1:0] = cc_reg;
			`CBU_OFF_STATUS: begin
				rd_word[`CBU_ST_EQUAL]   = ind_reg[0];
				rd_word[`CBU_ST_GREATER] = ind_reg[1];
				rd_word[`CBU_ST_LESS]    = ind_reg[2];
				rd_word[`CBU_ST_BUSY]    = state_reg;
				rd_word[`CBU_ST_TAKEN]   = taken_reg;
				rd_word[`CBU_ST_BADOP]   = badop_reg;
				rd_word[`CBU_ST_POS_LO+3:`CBU_ST_POS_LO] = pos_ind;
			end
			`CBU_OFF_ARSIGN: rd_word[3:0] = ar_sign_reg;
			`CBU_OFF_INDIR:  rd_word[ADDR_W-1:0] = indir_reg;
			default: begin
				if ((woff & `CBU_INDEX_MASK) == `CBU_OFF_INDEX && woff[5:2] != 4'h0) begin
					rd_word[ADDR_W-1:0] = index_mem[woff[5:2]];
				end
			end
		endcase
	end

	// ==========================================================
	// APB answer: one wait state, data and error registered with pready

	// the wait state keeps every bus output straight from a flip-flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				prdata  <= pwrite ? 32'h00000000 : rd_word;
				pslverr <= ~is_mapped(paddr);
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

/* File: sim/cbu_seq_model.sv */
/*
 Sequencer model: the APB master in front of the compare and branch unit.
 Assumes one pclk domain; the bench calls xfer for every register access.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// apb master
module cbu_seq_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [11:0] paddr,
	output var  logic [31:0] pwdata
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// one transfer; request held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no own limit: a dead slave is left to the bench watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		// released lines must not look like a held request
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;
		pwdata  <= ~d;
	endtask
endmodule
`default_nettype wire

/* File: sim/cbu_top_sva.sv */
/*
 Checker for the compare and branch unit, bound to its top ports.
 Assumes ce stays high and a master that holds requests until pready.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// port checks
module cbu_top_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        instr_done
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic        acc;
	logic        rdq;
	logic        go;
	logic [24:0] reg_sh;
	logic [24:0] mem_sh;
	logic [3:0]  sgn_sh;
	// transfer completion at this edge
	assign acc = psel && penable && pready;
	assign rdq = acc && !pwrite;
	assign go = acc && pwrite && paddr == 12'h000 && pwdata[0];
	// shadows of software-owned words; instructions must never alter them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_sh <= 25'h0000000;
			mem_sh <= 25'h0000000;
			sgn_sh <= 4'h0;
		end else if (acc && pwrite) begin
			if (paddr == 12'h008)
				reg_sh <= pwdata[24:0];
			if (paddr == 12'h010)
				mem_sh <= pwdata[24:0];
			if (paddr == 12'h024)
				sgn_sh <= pwdata[3:0];
		end
	end
	ind_onehot_a: assert property (rdq && paddr == 12'h020 |-> $onehot0(prdata[2:0]))
		else $error("several comparison indicators set");
	pos_sign_a: assert property (rdq && paddr == 12'h020 |-> prdata[11:8] == ~sgn_sh)
		else $error("sign indicator not inverse of sign");
	reg_keep_a: assert property (rdq && paddr == 12'h008 |-> prdata == {7'h00, reg_sh})
		else $error("register operand altered");
	mem_keep_a: assert property (rdq && paddr == 12'h010 |-> prdata == {7'h00, mem_sh})
		else $error("memory operand altered");
	idx_zero_a: assert property (rdq && paddr == 12'h040 |-> prdata == 32'h00000000)
		else $error("index register zero not zero");
	cc_width_a: assert property (rdq && paddr == 12'h01C |-> prdata[31:15] == 17'h00000)
		else $error("counter wider than fifteen bits");
	done_pulse_a: assert property (instr_done |=> !instr_done)
		else $error("done longer than one cycle");
	go_done_a: assert property (go |-> ##[2:3] instr_done)
		else $error("instruction did not finish in time");
	cover property (go ##[2:3] instr_done);
	cover property (rdq && paddr == 12'h020 && prdata[4]);
	cover property (acc && pslverr);
endmodule
bind cbu_top cbu_top_sva u_cbu_top_sva (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .instr_done(instr_done)
);
`default_nettype wire

/* File: sim/cbu_top_bench.sv */
/*
 Self-checking bench for the compare and branch unit.
 Assumes the sequencer model for bus traffic and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// bench top
module cbu_top_bench;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic        instr_done, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, st, v, cnt, lat;
	logic [3:0]  k, sg;
	integer      num_errors, total_checks;
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;
	cbu_top u_cbu_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_done(instr_done));
	cbu_seq_model u_cbu_seq_model (.pclk(pclk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	// cycles from go commit to the sampled done pulse
	always @(posedge pclk) begin
		if (psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[0])
			cnt <= 32'h00000000;
		else
			cnt <= cnt + 32'h00000001;
		if (instr_done === 1'b1)
			lat <= cnt;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		u_cbu_seq_model.xfer(1'b1, a, d, v, err);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] r);
		u_cbu_seq_model.xfer(1'b0, a, 32'h00000000, r, err);
	endtask
	// start an instruction and poll until busy drops
	task run(input logic f, input logic [3:0] x, input logic [5:0] op,
		input logic [3:0] ind, input logic [9:0] adr, input logic mw);
		integer n;
		wr(12'h004, {7'h00, f, x, op, ind, adr});
		wr(12'h000, {30'h00000000, mw, 1'b1});
		n = 0;
		do begin
			rd(12'h020, st);
			n = n + 1;
		end while (st[3] !== 1'b0 && n < 20);
		// a poll that runs out still busy counts as a mismatch
		chk({31'h00000000, st[3]}, 32'h00000000);
	endtask
	task cmp(input logic [5:0] op, input logic f, mw, input logic [24:0] rl, rh, ml, mh,
		input logic [2:0] e);
		wr(12'h008, {7'h00, rl});
		wr(12'h00C, {7'h00, rh});
		wr(12'h010, {7'h00, ml});
		wr(12'h014, {7'h00, mh});
		run(f, 4'h0, op, 4'h0, 10'h035, mw);
		chk({29'h00000000, st[2:0]}, {29'h00000000, e});
		chk(lat, 32'h00000002);
		rd(12'h008, v);
		chk(v, {7'h00, rl});
		rd(12'h010, v);
		chk(v, {7'h00, ml});
	endtask
	// branch from counter 0x100; indicators must survive the test
	task br(input logic [3:0] ind, input logic f, input logic [3:0] x, input logic [9:0] adr,
		input logic tk, input logic [14:0] tgt);
		logic [31:0] pre;
		rd(12'h020, pre);
		wr(12'h01C, 32'h00000100);
		run(f, x, 6'h30, ind, adr, 1'b0);
		chk({31'h00000000, st[4]}, {31'h00000000, tk});
		chk(lat, tk ? 32'h00000001 : 32'h00000002);
		chk({29'h00000000, st[2:0]}, {29'h00000000, pre[2:0]});
		rd(12'h01C, v);
		chk(v, {17'h00000, tk ? tgt : 15'h0101});
	endtask
	task jmp(input logic f, input logic [3:0] x, input logic [14:0] tgt);
		run(f, x, 6'h06, 4'h0, 10'h011, 1'b0);
		chk(lat, 32'h00000001);
		rd(12'h01C, v);
		chk(v, {17'h00000, tgt});
	endtask
	task summarize;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		#100000;
		num_errors = num_errors + 1;
		summarize;
	end
	// main sequence
	initial begin
		num_errors = 0;
		total_checks = 0;
		cnt = 32'h00000000;
		lat = 32'h00000000;
		ce = 1'b1;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h020, v);
		chk(v, 32'h00000F00);
		cmp(6'h2C, 0, 0, 25'h0000005, 0, 25'h0000003, 0, 3'b010);
		br(4'h7, 0, 4'h0, 10'h055, 1, 15'h0055);
		cmp(6'h2C, 0, 0, 25'h0000003, 0, 25'h0000005, 0, 3'b100);
		br(4'h5, 0, 4'h0, 10'h055, 1, 15'h0055);
		br(4'h6, 0, 4'h0, 10'h055, 0, 15'h0055);
		cmp(6'h2C, 0, 0, 25'h0000000, 0, 25'h1000000, 0, 3'b010);
		cmp(6'h2C, 0, 0, 25'h1000000, 0, 25'h0000000, 0, 3'b100);
		cmp(6'h2C, 0, 0, 25'h1000002, 0, 25'h1000005, 0, 3'b010);
		cmp(6'h2C, 0, 1, 25'h1000002, 25'h01, 25'h0000002, 25'h01, 3'b100);
		cmp(6'h2C, 0, 0, 25'h00A3B2C, 0, 25'h00A3B2B, 0, 3'b010);
		cmp(6'h2F, 0, 0, 25'h1000005, 0, 25'h0000007, 0, 3'b010);
		cmp(6'h2F, 0, 0, 25'h1000005, 0, 25'h1000007, 0, 3'b001);
		cmp(6'h2E, 0, 0, 25'h1000005, 0, 25'h1FFFFFA, 0, 3'b010);
		cmp(6'h2E, 0, 0, 25'h1000005, 0, 25'h0FFFFFA, 0, 3'b001);
		wr(12'h018, 32'h0000000F);
		cmp(6'h2C, 1, 0, 25'h00000F0, 0, 25'h000000F, 0, 3'b100);
		cmp(6'h2C, 0, 1, 25'h0000002, 25'h1000001, 25'h0000002, 25'h01, 3'b001);
		wr(12'h07C, 32'h00000200);
		br(4'h6, 0, 4'hF, 10'h010, 1, 15'h0210);
		wr(12'h02C, 32'h00000300);
		br(4'h6, 1, 4'hF, 10'h010, 1, 15'h0500);
		wr(12'h040, 32'h00000005);
		rd(12'h040, v);
		chk(v, 32'h00000000);
		wr(12'h028, 32'h00000005);
		br(4'h6, 0, 4'h0, 10'h055, 0, 15'h0055);
		wr(12'h028, 32'h00000000);
		br(4'h6, 0, 4'h0, 10'h055, 1, 15'h0055);
		sg = 4'h5;
		wr(12'h024, {28'h0000000, sg});
		for (k = 4'h1; k < 4'h5; k = k + 4'h1)
			br(k, 0, 4'h0, 10'h077, ~sg[4'h4 - k], 15'h0077);
		wr(12'h01C, 32'h00000100);
		jmp(0, 4'hF, 15'h0211);
		jmp(1, 4'h0, 15'h0300);
		// unknown opcode: one cycle, bad-op flag raised
		run(0, 4'h0, 6'h3F, 4'h0, 10'h000, 1'b0);
		chk({31'h00000000, st[5]}, 32'h00000001);
		chk(lat, 32'h00000001);
		rd(12'h3FC, v);
		chk({31'h00000000, err}, 32'h00000001);
		summarize;
	end
endmodule
`default_nettype wire
